// ===== rtl/coldstart_limiter.sv
`timescale 1ns/10ps
module coldstart_limiter
   import tt_sync_cfg_pkg::*;
#(
   parameter int W = 16
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic config_state_i,
   input wire logic [W-1:0] limit_i,
   input wire logic attempt_i,
   input wire logic answered_i,
   output logic allowed_o,
   output logic exhausted_o
);

   coldstart_state_e state_reg;
   logic [W-1:0] count_reg;
   logic [W:0] count_inc;

   assign count_inc = {1'b0, count_reg} + (W+1)'(1);

   always_ff @(posedge ref_clk_i) begin
      if (reset_i || config_state_i) begin
         state_reg <= cs_counting;
      end else begin
         unique case (state_reg)
            cs_counting: begin
               if (attempt_i && count_inc >= {1'b0, limit_i}) begin
                  state_reg <= cs_exhausted;
               end
            end
            cs_exhausted: begin
               state_reg <= cs_exhausted;
            end
         endcase
      end
   end

   // a valid answer from another node restarts the count
   always_ff @(posedge ref_clk_i) begin
      if (reset_i || config_state_i || answered_i) begin
         count_reg <= '0;
      end else if (attempt_i && state_reg == cs_counting) begin
         count_reg <= count_inc[W-1:0];
      end
   end

   assign allowed_o = state_reg == cs_counting && limit_i != '0 && !config_state_i;
   assign exhausted_o = state_reg == cs_exhausted;

endmodule

// ===== rtl/correction_combine.sv
`timescale 1ns/10ps
module correction_combine
   import tt_sync_cfg_pkg::*;
#(
   parameter int W = 16
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic apply_i,
   input wire logic signed [W:0] int_corr_i,
   input wire logic [W-1:0] limit_i,
   input wire logic [W-1:0] ext_value_i,
   input wire logic ext_enable_i,
   input wire logic ext_subtract_i,
   output logic signed [W+1:0] corr_o
);

   logic signed [W+1:0] int_x;
   logic signed [W+1:0] lim_x;
   logic signed [W+1:0] ext_x;
   logic signed [W+1:0] clamped;
   logic signed [W+1:0] corr_next;
   logic signed [W+1:0] corr_reg;

   // limit clamps the internal term only, never the external one
   always_comb begin
      int_x = {int_corr_i[W], int_corr_i};
      lim_x = {2'b00, limit_i};
      ext_x = {2'b00, ext_value_i};
      if (int_x > lim_x) begin
         clamped = lim_x;
      end else if (int_x < -lim_x) begin
         clamped = -lim_x;
      end else begin
         clamped = int_x;
      end
      corr_next = clamped;
      if (ext_enable_i) begin
         corr_next = ext_subtract_i ? clamped - ext_x : clamped + ext_x;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         corr_reg <= '0;
      end else if (apply_i) begin
         corr_reg <= corr_next;
      end
   end

   assign corr_o = corr_reg;

endmodule

// ===== rtl/tt_bus_clock_sync_config.sv
// Operation
// [RULE_01] parameter registers take writes only in config state; control register always
// [RULE_02] host programs drift limit as ceiling of cycle microticks times 1500 ppm
// [RULE_03] hold 16-bit external offset magnitude, combined with internal offset on request
// [RULE_04] hold 16-bit external rate magnitude, combined with internal rate on request
// [RULE_05] host writes correction control before idle time to act next cycle
// [RULE_06] offset enable bit 0 applies once, then hardware clears it
// [RULE_07] rate enable bit 2 applies once, then hardware clears it
// [RULE_08] offset sign bit 1: zero adds, one subtracts external offset
// [RULE_09] rate sign bit 3: zero adds, one subtracts external rate
// [RULE_10] internal offset clamped to offset limit; external offset never clamped
// [RULE_11] internal rate clamped to rate limit; external rate never clamped
// [RULE_12] count unanswered coldstarts; at limit stop until configuration again
// [RULE_13] coldstart limit zero means never coldstart
// [RULE_14] host keeps coldstart limit within zero to 32767
// [RULE_15] low byte of start-sequence register is nominal transmit length
// [RULE_16] high byte of start-sequence register is longest accepted receive length
// [RULE_17] config-only writes outside config state are dropped, value kept
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
module tt_bus_clock_sync_config
   import tt_sync_cfg_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [DATA_W-1:0] rdata_o,
   input wire logic config_state_i,
   input wire logic signed [DATA_W:0] offset_int_i,
   input wire logic signed [DATA_W:0] rate_int_i,
   input wire logic offset_apply_i,
   input wire logic rate_apply_i,
   output logic signed [DATA_W+1:0] offset_corr_o,
   output logic signed [DATA_W+1:0] rate_corr_o,
   input wire logic coldstart_attempt_i,
   input wire logic coldstart_answered_i,
   output logic coldstart_allowed_o,
   output logic coldstart_exhausted_o,
   output logic [DRIFT_W-1:0] max_drift_param_o,
   output logic [TSS_FIELD_W-1:0] tx_start_seq_nominal_o,
   output logic [TSS_FIELD_W-1:0] rx_start_seq_max_o,
   output logic [DATA_W-1:0] coldstart_attempts_param_o,
   output logic [DATA_W-1:0] offset_limit_param_o,
   output logic [DATA_W-1:0] rate_limit_param_o,
   output logic [DATA_W-1:0] ext_offset_param_o,
   output logic [DATA_W-1:0] ext_rate_param_o
);

   logic [DATA_W-1:0] cfg_reg [CFG_COUNT];
   logic [CTRL_W-1:0] ctrl_reg;
   logic [CTRL_W-1:0] ctrl_next;
   logic [DATA_W-1:0] read_next;
   logic [DATA_W-1:0] rdata_reg;
   logic ctrl_write;

   // configuration-only parameter registers
   genvar gi;
   generate
      for (gi = 0; gi < CFG_COUNT; gi++) begin : g_cfg
         always_ff @(posedge ref_clk_i) begin
            if (reset_i) begin
               cfg_reg[gi] <= PARAM_RESET;
            end else if (wr_i && addr_i == CFG_OFS[gi] && config_state_i) begin // [RULE_01] [RULE_17]
               cfg_reg[gi] <= wdata_i & CFG_MASK[gi];
            end
         end
      end
   endgenerate

   // correction control: writable in any state, enables self-clear on use
   assign ctrl_write = wr_i && addr_i == EXT_CTRL_OFS;

   always_comb begin
      ctrl_next = ctrl_reg;
      if (ctrl_write) begin
         // host write wins over a clear in the same cycle
         ctrl_next = wdata_i[CTRL_W-1:0]; // [RULE_01]
      end else begin
         if (offset_apply_i) begin
            ctrl_next[EXT_OFFSET_EN_BIT] = 1'b0; // [RULE_06]
         end
         if (rate_apply_i) begin
            ctrl_next[EXT_RATE_EN_BIT] = 1'b0; // [RULE_07]
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         ctrl_reg <= CTRL_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // read path: data in the cycle after the strobe only
   always_comb begin
      read_next = READ_NONE;
      for (int i = 0; i < CFG_COUNT; i++) begin
         if (addr_i == CFG_OFS[i]) begin
            read_next = cfg_reg[i];
         end
      end
      if (addr_i == EXT_CTRL_OFS) begin
         read_next = {{(DATA_W-CTRL_W){1'b0}}, ctrl_reg};
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         rdata_reg <= READ_NONE;
      end else begin
         rdata_reg <= rd_i ? read_next : READ_NONE;
      end
   end

   assign rdata_o = rdata_reg;

   // parameter outputs to the protocol engine
   assign max_drift_param_o = cfg_reg[IDX_DRIFT][DRIFT_W-1:0];
   assign tx_start_seq_nominal_o =
      cfg_reg[IDX_TSS][TSS_NOMINAL_LSB +: TSS_FIELD_W]; // [RULE_15]
   assign rx_start_seq_max_o = cfg_reg[IDX_TSS][TSS_MAX_LSB +: TSS_FIELD_W]; // [RULE_16]
   assign coldstart_attempts_param_o = cfg_reg[IDX_COLDSTART];
   assign offset_limit_param_o = cfg_reg[IDX_OFFSET_LIMIT];
   assign rate_limit_param_o = cfg_reg[IDX_RATE_LIMIT];
   assign ext_offset_param_o = cfg_reg[IDX_EXT_OFFSET]; // [RULE_03]
   assign ext_rate_param_o = cfg_reg[IDX_EXT_RATE]; // [RULE_04]

   // offset path: clamp internal term, then add or subtract external
   correction_combine #(
      .W(DATA_W)
   ) u_offset (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .apply_i(offset_apply_i),
      .int_corr_i(offset_int_i), // [RULE_10]
      .limit_i(cfg_reg[IDX_OFFSET_LIMIT]),
      .ext_value_i(cfg_reg[IDX_EXT_OFFSET]), // [RULE_03]
      .ext_enable_i(ctrl_reg[EXT_OFFSET_EN_BIT]), // [RULE_06]
      .ext_subtract_i(ctrl_reg[EXT_OFFSET_SIGN_BIT]), // [RULE_08]
      .corr_o(offset_corr_o)
   );

   // rate path
   correction_combine #(
      .W(DATA_W)
   ) u_rate (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .apply_i(rate_apply_i),
      .int_corr_i(rate_int_i), // [RULE_11]
      .limit_i(cfg_reg[IDX_RATE_LIMIT]),
      .ext_value_i(cfg_reg[IDX_EXT_RATE]), // [RULE_04]
      .ext_enable_i(ctrl_reg[EXT_RATE_EN_BIT]), // [RULE_07]
      .ext_subtract_i(ctrl_reg[EXT_RATE_SIGN_BIT]), // [RULE_09]
      .corr_o(rate_corr_o)
   );

   // coldstart attempt bookkeeping
   coldstart_limiter #(
      .W(DATA_W)
   ) u_coldstart (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .config_state_i(config_state_i),
      .limit_i(cfg_reg[IDX_COLDSTART]), // [RULE_12] [RULE_13]
      .attempt_i(coldstart_attempt_i),
      .answered_i(coldstart_answered_i),
      .allowed_o(coldstart_allowed_o),
      .exhausted_o(coldstart_exhausted_o)
   );

   // checks
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (reset_i);

   logic signed [DATA_W+1:0] ext_off_x;
   logic signed [DATA_W+1:0] ext_rate_x;
   logic signed [DATA_W+1:0] off_lim_x;
   logic signed [DATA_W+1:0] rate_lim_x;

   assign ext_off_x = {2'b00, cfg_reg[IDX_EXT_OFFSET]};
   assign ext_rate_x = {2'b00, cfg_reg[IDX_EXT_RATE]};
   assign off_lim_x = {2'b00, cfg_reg[IDX_OFFSET_LIMIT]};
   assign rate_lim_x = {2'b00, cfg_reg[IDX_RATE_LIMIT]};

   logic signed [DATA_W+1:0] off_int_x;
   logic signed [DATA_W+1:0] rate_int_x;

   assign off_int_x = {offset_int_i[DATA_W], offset_int_i};
   assign rate_int_x = {rate_int_i[DATA_W], rate_int_i};

   drift_locked_a: assert property ( // [RULE_17]
      wr_i && !config_state_i && addr_i == MAX_CYCLE_DRIFT_OFS
      |=> $stable(max_drift_param_o))
      else $error("drift limit changed outside config state");

   coldstart_write_a: assert property ( // [RULE_01]
      wr_i && config_state_i && addr_i == COLDSTART_LIMIT_OFS
      |=> coldstart_attempts_param_o == $past(wdata_i))
      else $error("coldstart limit not written in config state");

   ctrl_anytime_a: assert property ( // [RULE_01]
      ctrl_write && !config_state_i
      |=> ctrl_reg == $past(wdata_i[CTRL_W-1:0]))
      else $error("control write outside config state lost");

   offset_once_a: assert property ( // [RULE_06]
      offset_apply_i && ctrl_reg[EXT_OFFSET_EN_BIT] && !ctrl_write
      |=> !ctrl_reg[EXT_OFFSET_EN_BIT]
      && (addr_i != EXT_CTRL_OFS || !read_next[EXT_OFFSET_EN_BIT]))
      else $error("offset enable not cleared after use");

   rate_once_a: assert property ( // [RULE_07]
      rate_apply_i && ctrl_reg[EXT_RATE_EN_BIT] && !ctrl_write
      |=> !ctrl_reg[EXT_RATE_EN_BIT])
      else $error("rate enable not cleared after use");

   offset_sub_a: assert property ( // [RULE_08]
      offset_apply_i && ctrl_reg[EXT_OFFSET_EN_BIT] && ctrl_reg[EXT_OFFSET_SIGN_BIT]
      && offset_int_i == '0
      |=> offset_corr_o == -$past(ext_off_x))
      else $error("external offset not subtracted");

   offset_clamp_a: assert property ( // [RULE_10]
      offset_apply_i && !ctrl_reg[EXT_OFFSET_EN_BIT]
      && $signed({offset_int_i[DATA_W], offset_int_i}) > off_lim_x
      |=> offset_corr_o == $past(off_lim_x))
      else $error("internal offset not clamped");

   rate_add_a: assert property ( // [RULE_09]
      rate_apply_i && ctrl_reg[EXT_RATE_EN_BIT] && !ctrl_reg[EXT_RATE_SIGN_BIT]
      && rate_int_i == '0
      |=> rate_corr_o == $past(ext_rate_x))
      else $error("external rate not added");

   rate_clamp_a: assert property ( // [RULE_11]
      rate_apply_i && ctrl_reg[EXT_RATE_EN_BIT] && !ctrl_reg[EXT_RATE_SIGN_BIT]
      && $signed({rate_int_i[DATA_W], rate_int_i}) < -rate_lim_x
      |=> rate_corr_o == $past(ext_rate_x) - $past(rate_lim_x))
      else $error("rate clamp touched external value");

   coldstart_zero_a: assert property ( // [RULE_13]
      coldstart_attempts_param_o == '0 |-> !coldstart_allowed_o)
      else $error("coldstart allowed with zero limit");

   coldstart_stop_a: assert property ( // [RULE_12]
      coldstart_exhausted_o && !config_state_i
      |=> (!coldstart_allowed_o) [*2] or config_state_i)
      else $error("coldstart allowed after limit reached");

   tss_split_a: assert property ( // [RULE_15]
      wr_i && config_state_i && addr_i == START_SEQ_LENGTH_OFS
      |=> tx_start_seq_nominal_o == $past(wdata_i[7:0])
      && rx_start_seq_max_o == $past(wdata_i[15:8]))
      else $error("start sequence bytes misplaced");

   drift_write_a: assert property ( // [RULE_01]
      wr_i && config_state_i && addr_i == MAX_CYCLE_DRIFT_OFS
      |=> max_drift_param_o == $past(wdata_i[DRIFT_W-1:0]))
      else $error("drift limit not written in config state");

   ext_offset_write_a: assert property ( // [RULE_03]
      wr_i && config_state_i && addr_i == EXT_OFFSET_VALUE_OFS
      |=> ext_offset_param_o == $past(wdata_i))
      else $error("external offset value not stored");

   ext_rate_write_a: assert property ( // [RULE_04]
      wr_i && config_state_i && addr_i == EXT_RATE_VALUE_OFS
      |=> ext_rate_param_o == $past(wdata_i))
      else $error("external rate value not stored");

   tss_locked_a: assert property ( // [RULE_17]
      wr_i && !config_state_i && addr_i == START_SEQ_LENGTH_OFS
      |=> $stable(tx_start_seq_nominal_o) && $stable(rx_start_seq_max_o))
      else $error("start sequence changed outside config state");

   coldstart_locked_a: assert property ( // [RULE_17]
      wr_i && !config_state_i && addr_i == COLDSTART_LIMIT_OFS
      |=> $stable(coldstart_attempts_param_o))
      else $error("coldstart limit changed outside config state");

   offset_lim_locked_a: assert property ( // [RULE_17]
      wr_i && !config_state_i && addr_i == OFFSET_LIMIT_OFS
      |=> $stable(offset_limit_param_o))
      else $error("offset limit changed outside config state");

   rate_lim_locked_a: assert property ( // [RULE_17]
      wr_i && !config_state_i && addr_i == RATE_LIMIT_OFS
      |=> $stable(rate_limit_param_o))
      else $error("rate limit changed outside config state");

   ext_off_locked_a: assert property ( // [RULE_17]
      wr_i && !config_state_i && addr_i == EXT_OFFSET_VALUE_OFS
      |=> $stable(ext_offset_param_o))
      else $error("external offset changed outside config state");

   ext_rate_locked_a: assert property ( // [RULE_17]
      wr_i && !config_state_i && addr_i == EXT_RATE_VALUE_OFS
      |=> $stable(ext_rate_param_o))
      else $error("external rate changed outside config state");

   offset_clamp_add_a: assert property ( // [RULE_10]
      offset_apply_i && ctrl_reg[EXT_OFFSET_EN_BIT] && !ctrl_reg[EXT_OFFSET_SIGN_BIT]
      && off_int_x > off_lim_x
      |=> offset_corr_o == $past(off_lim_x) + $past(ext_off_x))
      else $error("clamped offset plus external value wrong");

   offset_clamp_sub_a: assert property ( // [RULE_10]
      offset_apply_i && ctrl_reg[EXT_OFFSET_EN_BIT] && ctrl_reg[EXT_OFFSET_SIGN_BIT]
      && off_int_x < -off_lim_x
      |=> offset_corr_o == -$past(off_lim_x) - $past(ext_off_x))
      else $error("clamped offset minus external value wrong");

   rate_sub_a: assert property ( // [RULE_09]
      rate_apply_i && ctrl_reg[EXT_RATE_EN_BIT] && ctrl_reg[EXT_RATE_SIGN_BIT]
      && rate_int_x <= rate_lim_x && rate_int_x >= -rate_lim_x
      |=> rate_corr_o == $past(rate_int_x) - $past(ext_rate_x))
      else $error("external rate not subtracted");

   rate_plain_a: assert property ( // [RULE_11]
      rate_apply_i && !ctrl_reg[EXT_RATE_EN_BIT] && rate_int_x < -rate_lim_x
      |=> rate_corr_o == -$past(rate_lim_x))
      else $error("internal rate not clamped");

   offset_hold_a: assert property ( // [RULE_06]
      !offset_apply_i |=> $stable(offset_corr_o))
      else $error("offset correction moved without apply");

   rate_hold_a: assert property ( // [RULE_07]
      !rate_apply_i |=> $stable(rate_corr_o))
      else $error("rate correction moved without apply");

   offset_en_keep_a: assert property ( // [RULE_06]
      !ctrl_write && !offset_apply_i |=> $stable(ctrl_reg[EXT_OFFSET_EN_BIT]))
      else $error("offset enable changed on its own");

   rate_en_keep_a: assert property ( // [RULE_07]
      !ctrl_write && !rate_apply_i |=> $stable(ctrl_reg[EXT_RATE_EN_BIT]))
      else $error("rate enable changed on its own");

   coldstart_reopen_a: assert property ( // [RULE_12]
      config_state_i |=> !coldstart_exhausted_o)
      else $error("configuration did not restart coldstart");

   coldstart_still_a: assert property ( // [RULE_12]
      !coldstart_attempt_i && !config_state_i |=> $stable(coldstart_exhausted_o))
      else $error("coldstart state moved without attempt");

   read_slot_a: assert property (
      rd_i |=> ##1 rdata_o == READ_NONE || $past(rd_i))
      else $error("read data stood beyond one cycle");

endmodule

// ===== rtl/tt_sync_cfg_pkg.sv
package tt_sync_cfg_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int CFG_COUNT = 7;

   // register offsets
   localparam logic [7:0] MAX_CYCLE_DRIFT_OFS = 8'hb8;
   localparam logic [7:0] START_SEQ_LENGTH_OFS = 8'hba;
   localparam logic [7:0] COLDSTART_LIMIT_OFS = 8'hc0;
   localparam logic [7:0] OFFSET_LIMIT_OFS = 8'hda;
   localparam logic [7:0] RATE_LIMIT_OFS = 8'hdc;
   localparam logic [7:0] EXT_OFFSET_VALUE_OFS = 8'hf4;
   localparam logic [7:0] EXT_RATE_VALUE_OFS = 8'hf6;
   localparam logic [7:0] EXT_CTRL_OFS = 8'hf8;

   // slots of the configuration-only register array
   localparam int IDX_DRIFT = 0;
   localparam int IDX_TSS = 1;
   localparam int IDX_COLDSTART = 2;
   localparam int IDX_OFFSET_LIMIT = 3;
   localparam int IDX_RATE_LIMIT = 4;
   localparam int IDX_EXT_OFFSET = 5;
   localparam int IDX_EXT_RATE = 6;

   localparam logic [7:0] CFG_OFS [CFG_COUNT] = '{
      MAX_CYCLE_DRIFT_OFS, START_SEQ_LENGTH_OFS, COLDSTART_LIMIT_OFS,
      OFFSET_LIMIT_OFS, RATE_LIMIT_OFS, EXT_OFFSET_VALUE_OFS, EXT_RATE_VALUE_OFS};

   // writable bits per slot; the drift limit is 10 bits wide
   localparam logic [15:0] CFG_MASK [CFG_COUNT] = '{
      16'h03ff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff};

   // field positions
   localparam int DRIFT_W = 10;
   localparam int TSS_FIELD_W = 8;
   localparam int TSS_NOMINAL_LSB = 0;
   localparam int TSS_MAX_LSB = 8;
   localparam int CTRL_W = 4;
   localparam int EXT_OFFSET_EN_BIT = 0;
   localparam int EXT_OFFSET_SIGN_BIT = 1;
   localparam int EXT_RATE_EN_BIT = 2;
   localparam int EXT_RATE_SIGN_BIT = 3;

   // reset values
   localparam logic [15:0] PARAM_RESET = 16'h0000;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam logic [15:0] READ_NONE = 16'h0000;

   typedef enum logic {cs_counting, cs_exhausted} coldstart_state_e;

endpackage

// ===== verification/tt_bus_clock_sync_config_bench.sv
`timescale 1ns/10ps
module tt_bus_clock_sync_config_bench;
   import tt_sync_cfg_pkg::*;

   logic clk;
   logic rst;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic wr;
   logic rd;
   logic [DATA_W-1:0] rdata;
   logic cfg;
   logic signed [DATA_W:0] off_int;
   logic signed [DATA_W:0] rate_int;
   logic off_ap;
   logic rate_ap;
   logic signed [DATA_W+1:0] off_corr;
   logic signed [DATA_W+1:0] rate_corr;
   logic cs_att;
   logic cs_ans;
   logic cs_ok;
   logic cs_exh;
   logic [DRIFT_W-1:0] drift;
   logic [TSS_FIELD_W-1:0] tss_nom;
   logic [TSS_FIELD_W-1:0] tss_max;
   logic [DATA_W-1:0] cs_lim;
   logic [DATA_W-1:0] off_lim;
   logic [DATA_W-1:0] rate_lim;
   logic [DATA_W-1:0] ext_off;
   logic [DATA_W-1:0] ext_rate;
   int bad_count = 0;
   int compares = 0;
   // drift, tss, coldstart, offset limit, rate limit, ext offset, ext rate
   logic [15:0] vals [CFG_COUNT] = '{16'h012c, 16'h2a05, 16'h0002, 16'h0064, 16'h0032,
      16'h0028, 16'h01f4};

   tt_bus_clock_sync_config i_tt_bus_clock_sync_config (
      .ref_clk_i(clk), .reset_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .config_state_i(cfg), .offset_int_i(off_int), .rate_int_i(rate_int),
      .offset_apply_i(off_ap), .rate_apply_i(rate_ap), .offset_corr_o(off_corr),
      .rate_corr_o(rate_corr), .coldstart_attempt_i(cs_att), .coldstart_answered_i(cs_ans),
      .coldstart_allowed_o(cs_ok), .coldstart_exhausted_o(cs_exh), .max_drift_param_o(drift),
      .tx_start_seq_nominal_o(tss_nom), .rx_start_seq_max_o(tss_max),
      .coldstart_attempts_param_o(cs_lim), .offset_limit_param_o(off_lim),
      .rate_limit_param_o(rate_lim), .ext_offset_param_o(ext_off), .ext_rate_param_o(ext_rate)
   );

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // read data stands in the cycle after the strobe only
   task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
      @(posedge clk);
      #1;
      chk(rdata, 16'h0000);
   endtask

   task automatic apply(input bit is_rate, input logic signed [16:0] v);
      @(posedge clk);
      if (is_rate) begin
         rate_int <= v;
         rate_ap <= 1'b1;
      end else begin
         off_int <= v;
         off_ap <= 1'b1;
      end
      @(posedge clk);
      rate_ap <= 1'b0;
      off_ap <= 1'b0;
      #1;
   endtask

   task automatic cs_pulse(input bit answered);
      @(posedge clk);
      if (answered) cs_ans <= 1'b1;
      else cs_att <= 1'b1;
      @(posedge clk);
      cs_ans <= 1'b0;
      cs_att <= 1'b0;
      #1;
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      #20000;
      bad_count++;
      summarize();
   end

   initial begin
      rst = 1'b1;
      addr = 8'h00;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
      cfg = 1'b1;
      off_int = 17'h00000;
      rate_int = 17'h00000;
      off_ap = 1'b0;
      rate_ap = 1'b0;
      cs_att = 1'b0;
      cs_ans = 1'b0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < CFG_COUNT; i++) rd_reg(CFG_OFS[i], PARAM_RESET);
      rd_reg(EXT_CTRL_OFS, 16'h0000);
      // programming in configuration state
      for (int i = 0; i < CFG_COUNT; i++) wr_reg(CFG_OFS[i], vals[i]);
      for (int i = 0; i < CFG_COUNT; i++) rd_reg(CFG_OFS[i], vals[i] & CFG_MASK[i]);
      chk(drift, 10'h12c);
      chk(tss_nom, 8'h05);
      chk(tss_max, 8'h2a);
      chk(cs_lim, 16'h0002);
      chk(off_lim, 16'h0064);
      chk(rate_lim, 16'h0032);
      chk(ext_off, 16'h0028);
      chk(ext_rate, 16'h01f4);
      // writes outside configuration are dropped
      @(posedge clk);
      cfg <= 1'b0;
      for (int i = 0; i < CFG_COUNT; i++) wr_reg(CFG_OFS[i], ~vals[i]);
      for (int i = 0; i < CFG_COUNT; i++) rd_reg(CFG_OFS[i], vals[i] & CFG_MASK[i]);
      wr_reg(8'hb0, 16'hbeef);
      rd_reg(8'hb0, READ_NONE);
      // offset: clamp internal to 100, add or subtract ext 40
      wr_reg(EXT_CTRL_OFS, 16'h0001);
      apply(1'b0, 17'sd300);
      chk(off_corr, 18'sd140);
      rd_reg(EXT_CTRL_OFS, 16'h0000);
      apply(1'b0, 17'sd300);
      chk(off_corr, 18'sd100);
      wr_reg(EXT_CTRL_OFS, 16'h0003);
      apply(1'b0, -17'sd300);
      chk(off_corr, -18'sd140);
      rd_reg(EXT_CTRL_OFS, 16'h0002);
      wr_reg(EXT_CTRL_OFS, 16'h0003);
      apply(1'b0, 17'sd0);
      chk(off_corr, -18'sd40);
      // rate: clamp internal to 50, ext 500 not clamped
      wr_reg(EXT_CTRL_OFS, 16'h000c);
      apply(1'b1, 17'sd20);
      chk(rate_corr, -18'sd480);
      rd_reg(EXT_CTRL_OFS, 16'h0008);
      wr_reg(EXT_CTRL_OFS, 16'h0004);
      apply(1'b1, -17'sd70);
      chk(rate_corr, 18'sd450);
      apply(1'b1, -17'sd70);
      chk(rate_corr, -18'sd50);
      wr_reg(EXT_CTRL_OFS, 16'h0004);
      apply(1'b1, 17'sd0);
      chk(rate_corr, 18'sd500);
      // coldstart limit 2
      chk(cs_ok, 1'b1);
      cs_pulse(1'b0);
      cs_pulse(1'b1);
      cs_pulse(1'b0);
      chk(cs_exh, 1'b0);
      cs_pulse(1'b0);
      chk(cs_exh, 1'b1);
      chk(cs_ok, 1'b0);
      cs_pulse(1'b1);
      chk(cs_exh, 1'b1);
      @(posedge clk);
      cfg <= 1'b1;
      wr_reg(COLDSTART_LIMIT_OFS, 16'h0000);
      #1;
      chk(cs_exh, 1'b0);
      @(posedge clk);
      cfg <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(cs_ok, 1'b0);
      cs_pulse(1'b0);
      chk(cs_ok, 1'b0);
      summarize();
   end
endmodule
